// file: logic/rsr_consts.vh
// Register offsets, field positions and timing for the rail enable register slice
`ifndef RSR_CONSTS_VH
`define RSR_CONSTS_VH
`define RSR_OFF_SYS_CTRL 8'h07
`define RSR_OFF_RAIL_EN 8'h10
`define RSR_OFF_RAIL_STAT 8'h11
`define RSR_OFF_VCHG 8'h20
`define RSR_OFF_BA_T1 8'h23
`define RSR_OFF_BA_T2 8'h24
`define RSR_DLY_LSB 4
`define RSR_EN_LINEAR2 6
`define RSR_EN_LINEAR1 4
`define RSR_EN_BUCK_B 2
`define RSR_EN_BUCK_A 0
`define RSR_ST_BUCKS 7
`define RSR_ST_LINEARS 6
`define RSR_ST_LINEAR2 5
`define RSR_ST_LINEAR1 4
`define RSR_ST_BUCK_B 2
`define RSR_ST_BUCK_A 0
`define RSR_VC_B_SEL 5
`define RSR_VC_B_GO 4
`define RSR_VC_A_SEL 1
`define RSR_VC_A_GO 0
`define RSR_RAIL_EN_RESET 8'h55
`define RSR_RAIL_EN_MASK 8'h55
`define RSR_RAIL_STAT_RESET 8'h00
`define RSR_VCHG_RESET 8'h00
`define RSR_VCHG_MASK 8'h33
`define RSR_CODE_EXT 5'h00
`define RSR_CODE_MAX 5'h19
`define RSR_RATE_MAX 4'hA
`define RSR_STEP_A_MV 50
`define RSR_STEP_B_MV 100
`define RSR_CLK_MHZ 10
`define RSR_HALF_MS_US 500
`define RSR_HALF_MS_CYCLES (`RSR_HALF_MS_US * `RSR_CLK_MHZ)
`define RSR_DLY_UNITS_MAX 5'h16
`endif

// file: logic/rsr_regs.v
// Rail enable, sequencing, status and buck target register slice
// Operation
// - After the external enable rises, each rail starts after the delay the 3-bit code picks from its table.
// - The enable register bits 6, 4, 2, 0 switch linear2, linear1, buck b, buck a and reset to one.
// - The read-only status register shows each rail valid plus both-bucks and both-linears flags, reset zero.
// - The select bits 1 and 5 pick target one (0) or target two (1) for buck a and buck b.
// - The go bits 0 and 4 hold the output when 0 and ramp to the selected target when 1; register resets zero.
// - Buck a target one decodes code 01 as 0.80 V rising 0.05 V per code to 2.00 V at 19, codes above clamp.
// - Buck a target two uses the same encoding with a factory-set reset value.
// - A target code of zero hands the buck output to external control.
// - Bits 7..5 of both buck a target registers are reserved and reset to zero.
// - The delay code sits in bits 6..4 of system control one with a factory default.
// - A ramp moves at the buck's 4-bit rate, 0 instant and 1 to A giving 1 to 10 mV/us.
// - Buck b targets decode code 01 as 1.0 V up to 3.4 V at 19, code zero meaning external control.
`include "rsr_consts.vh"
module rsr_regs #(
    parameter [2:0] DELAY_CODE_RESET = 3'h2,
    parameter [4:0] BUCK_A_T1_RESET = 5'h09,
    parameter [4:0] BUCK_A_T2_RESET = 5'h09,
    parameter [4:0] BUCK_B_START = 5'h09,
    parameter integer HALF_MS_CYCLES = `RSR_HALF_MS_CYCLES
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire ext_enable_i,
    input wire [3:0] rail_in_spec_i,
    input wire [4:0] buck_b_first_target_i,
    input wire [4:0] buck_b_second_target_i,
    input wire [3:0] buck_a_ramp_rate_i,
    input wire [3:0] buck_b_ramp_rate_i,
    output reg [3:0] rail_on_o,
    output wire [9:0] buck_setpoint_o,
    output wire [1:0] buck_ext_ctrl_o
);
    // Rail index order: 0 buck a, 1 buck b, 2 linear1, 3 linear2
    reg [2:0] power_on_delay_code;
    reg [7:0] rail_enable;
    reg [7:0] rail_valid_status;
    reg [7:0] buck_voltage_change_ctrl;
    reg [4:0] buck_a_target_code_one;
    reg [4:0] buck_a_target_code_two;
    reg [15:0] tick_cnt;
    reg [4:0] half_ms;
    reg enable_seen;
    wire [3:0] en_bits;

    // Power-on delay in half-millisecond units per code and rail
    function [4:0] rsr_delay_units;
        input [2:0] code;
        input [1:0] rail;
        reg [19:0] row;
        begin
            row = 20'h00000;
            case (code)
                3'h0: row = {5'h02, 5'h02, 5'h02, 5'h02};
                3'h1: row = {5'h04, 5'h04, 5'h03, 5'h02};
                3'h2: row = {5'h0C, 5'h06, 5'h04, 5'h03};
                3'h3: row = {5'h02, 5'h02, 5'h04, 5'h03};
                3'h4: row = {5'h0C, 5'h06, 5'h04, 5'h03};
                3'h5: row = {5'h04, 5'h04, 5'h03, 5'h03};
                3'h6: row = {5'h03, 5'h02, 5'h04, 5'h06};
                default: row = {5'h16, 5'h0C, 5'h06, 5'h04};
            endcase
            rsr_delay_units = row[rail*5 +: 5];
        end
    endfunction

    // Clamp codes above the top entry
    function [4:0] rsr_clamp;
        input [4:0] code;
        begin
            rsr_clamp = (code > `RSR_CODE_MAX) ? `RSR_CODE_MAX : code;
        end
    endfunction

    assign en_bits = {rail_enable[`RSR_EN_LINEAR2], rail_enable[`RSR_EN_LINEAR1],
                      rail_enable[`RSR_EN_BUCK_B], rail_enable[`RSR_EN_BUCK_A]};

    // Register writes and status capture
    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            power_on_delay_code <= DELAY_CODE_RESET;
            rail_enable <= `RSR_RAIL_EN_RESET;
            rail_valid_status <= `RSR_RAIL_STAT_RESET;
            buck_voltage_change_ctrl <= `RSR_VCHG_RESET;
            buck_a_target_code_one <= BUCK_A_T1_RESET;
            buck_a_target_code_two <= BUCK_A_T2_RESET;
        end
        else
        begin
            rail_valid_status <= {&rail_in_spec_i[1:0], &rail_in_spec_i[3:2], rail_in_spec_i[3],
                                  rail_in_spec_i[2], 1'b0, rail_in_spec_i[1], 1'b0, rail_in_spec_i[0]};
            if (reg_wr_i)
            begin
                case (reg_addr_i)
                    `RSR_OFF_SYS_CTRL: power_on_delay_code <= reg_wdata_i[`RSR_DLY_LSB +: 3];
                    `RSR_OFF_RAIL_EN: rail_enable <= reg_wdata_i & `RSR_RAIL_EN_MASK;
                    `RSR_OFF_VCHG: buck_voltage_change_ctrl <= reg_wdata_i & `RSR_VCHG_MASK;
                    `RSR_OFF_BA_T1: buck_a_target_code_one <= reg_wdata_i[4:0];
                    `RSR_OFF_BA_T2: buck_a_target_code_two <= reg_wdata_i[4:0];
                    default: ;
                endcase
            end
        end
    end

    // Registered read data, unmapped reads give zero
    always @(posedge core_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RSR_OFF_SYS_CTRL: reg_rdata_o <= {1'b0, power_on_delay_code, 4'h0};
                `RSR_OFF_RAIL_EN: reg_rdata_o <= rail_enable;
                `RSR_OFF_RAIL_STAT: reg_rdata_o <= rail_valid_status;
                `RSR_OFF_VCHG: reg_rdata_o <= buck_voltage_change_ctrl;
                `RSR_OFF_BA_T1: reg_rdata_o <= {3'h0, buck_a_target_code_one};
                `RSR_OFF_BA_T2: reg_rdata_o <= {3'h0, buck_a_target_code_two};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Half-millisecond timer running while the external enable is high
    always @(posedge core_clk_i)
    begin
        if (reset_i || !ext_enable_i)
        begin
            tick_cnt <= 16'h0000;
            half_ms <= 5'h00;
            enable_seen <= 1'b0;
        end
        else
        begin
            enable_seen <= 1'b1;
            if (half_ms != `RSR_DLY_UNITS_MAX)
            begin
                if (tick_cnt == HALF_MS_CYCLES[15:0] - 16'h0001)
                begin
                    tick_cnt <= 16'h0000;
                    half_ms <= half_ms + 5'h01;
                end
                else
                    tick_cnt <= tick_cnt + 16'h0001;
            end
        end
    end

    // Rail switches: delay elapsed and enable bit set
    always @(posedge core_clk_i)
    begin : seq_blk
        integer r;
        if (reset_i)
            rail_on_o <= 4'h0;
        else
            for (r = 0; r < 4; r = r + 1)
                rail_on_o[r] <= ext_enable_i && enable_seen && en_bits[r] &&
                                (half_ms >= rsr_delay_units(power_on_delay_code, r[1:0]));
    end

    // Per-buck target selection and ramp engine
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : g_buck
            wire sel = buck_voltage_change_ctrl[b ? `RSR_VC_B_SEL : `RSR_VC_A_SEL];
            wire go = buck_voltage_change_ctrl[b ? `RSR_VC_B_GO : `RSR_VC_A_GO];
            wire [4:0] t_one = b ? buck_b_first_target_i : buck_a_target_code_one;
            wire [4:0] t_two = b ? buck_b_second_target_i : buck_a_target_code_two;
            wire [3:0] rate_raw = b ? buck_b_ramp_rate_i : buck_a_ramp_rate_i;
            wire [4:0] target_raw = sel ? t_two : t_one;
            wire [4:0] target = rsr_clamp(target_raw);
            wire [3:0] rate = (rate_raw > `RSR_RATE_MAX) ? `RSR_RATE_MAX : rate_raw;
            // Full-width product, cut to the counter width on purpose
            wire [31:0] step_mv = b ? `RSR_STEP_B_MV : `RSR_STEP_A_MV;
            wire [31:0] step_full = (step_mv * `RSR_CLK_MHZ) / {28'h0000000, rate};
            wire [10:0] step_cycles = (rate == 4'h0) ? 11'h000 : step_full[10:0];
            reg [4:0] setpoint;
            reg [10:0] wait_cnt;
            reg ext_ctrl;
            assign buck_setpoint_o[b*5 +: 5] = setpoint;
            assign buck_ext_ctrl_o[b] = ext_ctrl;
            always @(posedge core_clk_i)
            begin
                if (reset_i)
                begin
                    setpoint <= b ? BUCK_B_START : rsr_clamp(BUCK_A_T1_RESET);
                    wait_cnt <= 11'h000;
                    ext_ctrl <= 1'b0;
                end
                else if (go)
                begin
                    ext_ctrl <= (target_raw == `RSR_CODE_EXT);
                    if (target_raw == `RSR_CODE_EXT || setpoint == target)
                        wait_cnt <= 11'h000;
                    else if (rate == 4'h0)
                        setpoint <= target;
                    else if (wait_cnt + 11'h001 >= step_cycles)
                    begin
                        wait_cnt <= 11'h000;
                        setpoint <= (setpoint < target) ? setpoint + 5'h01 : setpoint - 5'h01;
                    end
                    else
                        wait_cnt <= wait_cnt + 11'h001;
                end
            end
        end
    endgenerate
endmodule

// file: bench/rsr_regs_props.sv
// Port assertions for the rail enable register slice
module rsr_regs_props #(
    parameter integer HALF_MS_CYCLES = 5000
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire ext_enable_i,
    input wire [3:0] rail_on_o,
    input wire [9:0] buck_setpoint_o,
    input wire [1:0] buck_ext_ctrl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // Read request at one offset
    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0) reset_i
        |=> rail_on_o == 4'h0 && buck_ext_ctrl_o == 2'h0)
        else $error("outputs not cleared by reset");
    chk_enable_drop: assert property (!ext_enable_i |=> rail_on_o == 4'h0)
        else $error("rail stays on without external enable");
    chk_start_gap: assert property ($rose(ext_enable_i) && HALF_MS_CYCLES >= 4
        |-> (rail_on_o == 4'h0) [*8])
        else $error("rail started before its shortest delay");
    chk_unmapped_zero: assert property (reg_rd_i
        && !(reg_addr_i inside {8'h07, 8'h10, 8'h11, 8'h20, 8'h23, 8'h24}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_enable_reserved: assert property (s_rd(8'h10) |=> (reg_rdata_o & 8'hAA) == 8'h00)
        else $error("enable reserved bits set");
    chk_target_reserved: assert property (s_rd(8'h23) or s_rd(8'h24) |=> reg_rdata_o[7:5] == 3'h0)
        else $error("target reserved bits set");
    chk_status_summary: assert property (s_rd(8'h11)
        |=> reg_rdata_o[7] == (reg_rdata_o[0] & reg_rdata_o[2])
        && reg_rdata_o[6] == (reg_rdata_o[4] & reg_rdata_o[5]) && (reg_rdata_o & 8'h0A) == 8'h00)
        else $error("status summary bits wrong");
    chk_setpoint_range: assert property (buck_setpoint_o[4:0] <= 5'h19 && buck_setpoint_o[9:5] <= 5'h19)
        else $error("setpoint beyond top code");
    chk_ext_freeze: assert property (buck_ext_ctrl_o[0] && $past(buck_ext_ctrl_o[0])
        |-> $stable(buck_setpoint_o[4:0]))
        else $error("setpoint moved under external control");
    chk_b_ext_freeze: assert property (buck_ext_ctrl_o[1] && $past(buck_ext_ctrl_o[1])
        |-> $stable(buck_setpoint_o[9:5]))
        else $error("buck b setpoint moved under external control");
endmodule
bind rsr_regs rsr_regs_props #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) i_rsr_regs_props (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ext_enable_i(ext_enable_i), .rail_on_o(rail_on_o), .buck_setpoint_o(buck_setpoint_o),
    .buck_ext_ctrl_o(buck_ext_ctrl_o));

// file: bench/rsr_host.sv
// Host controller model driving the register byte port
module rsr_host (
    input wire core_clk_i,
    input wire [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
    end
    // One write strobe, then released lines show inverted junk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
    endtask
    // One read strobe, data taken once the registered answer lands
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        {addr_o, rd_o} <= {a, 1'b1};
        @(posedge core_clk_i);
        {addr_o, rd_o} <= {~a, 1'b0};
        #1 d = rdata_i;
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the rail enable register slice
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ext_enable_i = 1'b0;
    logic [3:0] spec = 4'h0;
    logic [3:0] rate_a = 4'h0;
    logic [3:0] rate_b = 4'h0;
    logic [4:0] b_one = 5'h05;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd;
    wire [3:0] rail_on;
    wire [9:0] setpt;
    wire [1:0] ext_ctrl;
    int fail_count = 0;
    int checks_done = 0;
    int t[4];
    logic [7:0] got;
    // Rows: in-spec, offset, write data, expected readback
    logic [27:0] rows[10] = '{28'h010FF55, 28'h010AA00, 28'h020FF33, 28'h023FF1F, 28'h024E505,
        28'h007FF70, 28'h030FF00, 28'h511FF11, 28'hF1100F5, 28'hA110024};
    logic [15:0] rst_tab[6] = '{16'h0720, 16'h1055, 16'h1100, 16'h2000, 16'h2309, 16'h2409};
    always #50 core_clk_i = ~core_clk_i;
    rsr_regs #(.HALF_MS_CYCLES(4)) i_rsr_regs (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_enable_i(ext_enable_i),
        .rail_in_spec_i(spec), .buck_b_first_target_i(b_one), .buck_b_second_target_i(5'h10),
        .buck_a_ramp_rate_i(rate_a), .buck_b_ramp_rate_i(rate_b), .rail_on_o(rail_on), .buck_setpoint_o(setpt),
        .buck_ext_ctrl_o(ext_ctrl));
    rsr_host i_rsr_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd));
    task check(input string what, input logic [11:0] exp, input logic [11:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        foreach (rows[i])
        begin
            @(posedge core_clk_i) spec <= rows[i][27:24];
            i_rsr_host.wr(rows[i][23:16], rows[i][15:8]);
            i_rsr_host.rd(rows[i][23:16], got);
            check("register", rows[i][7:0], got);
        end
        // Longest delay code, buck b held off by its enable bit
        i_rsr_host.wr(8'h07, 8'h70);
        i_rsr_host.wr(8'h10, 8'h51);
        ext_enable_i <= 1'b1;
        t = '{-1, -1, -1, -1};
        for (int n = 0; n < 120; n++)
        begin
            tick(1);
            for (int r = 0; r < 4; r++)
                if (rail_on[r] === 1'b1 && t[r] < 0)
                    t[r] = n;
        end
        foreach (t[r])
            check("rail delay", 1, r == 1 ? t[r] < 0 : t[r] >= 4 * r_units(r) && t[r] <= 4 * r_units(r) + 3);
        @(posedge core_clk_i) ext_enable_i <= 1'b0;
        tick(2);
        check("rails off", 0, rail_on);
        // Target select, clamp, hold, slow ramp and external control on buck a
        i_rsr_host.wr(8'h23, 8'h0C);
        i_rsr_host.wr(8'h24, 8'h1F);
        i_rsr_host.wr(8'h20, 8'h33);
        tick(3);
        check("setpoint two", 10'h219, setpt);
        i_rsr_host.wr(8'h20, 8'h11);
        tick(3);
        check("setpoint one", 10'h0AC, setpt);
        i_rsr_host.wr(8'h20, 8'h00);
        i_rsr_host.wr(8'h23, 8'h02);
        tick(3);
        check("setpoint hold", 10'h0AC, setpt);
        i_rsr_host.wr(8'h20, 8'h01);
        tick(3);
        check("setpoint jump", 5'h02, setpt[4:0]);
        @(posedge core_clk_i) rate_a <= 4'hA;
        i_rsr_host.wr(8'h23, 8'h04);
        tick(20);
        check("ramp early", 5'h02, setpt[4:0]);
        tick(100);
        check("ramp done", 5'h04, setpt[4:0]);
        i_rsr_host.wr(8'h23, 8'h00);
        tick(3);
        check("external", 6'h24, {ext_ctrl[0], setpt[4:0]});
        // Buck b: paced ramp at 100 cycles per step, then external control
        @(posedge core_clk_i) rate_b <= 4'hA;
        b_one <= 5'h07;
        i_rsr_host.wr(8'h20, 8'h11);
        tick(150);
        check("b ramp mid", 5'h06, setpt[9:5]);
        tick(100);
        check("b ramp done", 5'h07, setpt[9:5]);
        @(posedge core_clk_i) b_one <= 5'h00;
        tick(3);
        check("b external", 12'hCE4, {ext_ctrl, setpt});
        // Second reset: every register back to its default
        @(posedge core_clk_i) reset_i <= 1'b1;
        spec <= 4'h0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        foreach (rst_tab[i])
        begin
            i_rsr_host.rd(rst_tab[i][15:8], got);
            check("reset value", rst_tab[i][7:0], got);
        end
        check("reset outputs", 12'h129, {ext_ctrl, setpt});
        final_report();
    end
    // Delay table in half-ms units for code 7
    function automatic int r_units(input int r);
        return r == 0 ? 4 : r == 1 ? 6 : r == 2 ? 12 : 22;
    endfunction
endmodule
